// ### src/aow_consts.svh
// constants for the converter offset-write and conversion handshake block
`ifndef AOW_CONSTS_SVH
`define AOW_CONSTS_SVH
`define AOW_DATA_W 15
`define AOW_OFS_W 12
`define AOW_RES_W 14
`define AOW_MODE_IMM 2'h1
`define AOW_MODE_DLY 2'h2
`define AOW_CLK_NS 50
`define AOW_CONV_NS 300
`define AOW_CONV_CYC ((`AOW_CONV_NS + `AOW_CLK_NS - 1) / `AOW_CLK_NS)
`endif

// ### src/aow_core.sv
// converter digital side: offset register, conversion handshake, data bus
`include "aow_consts.svh"

// How it works
// - offset kept until next write or reset
// - any write between conversions replaces offset
// - sample_start_n falling edge starts conversion
// - sample taken at that falling edge
// - busy_n low for whole conversion
// - busy_n rises at end of conversion
// - data driven only while cs and rd low
// - output register update by mode
module aow_core #(
    parameter int CONV_CYCLES = `AOW_CONV_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_sample_start_n,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [1:0] i_mode,
    input wire logic [`AOW_DATA_W-1:0] i_data,
    input wire logic [`AOW_RES_W-1:0] i_adc_code,
    output logic [`AOW_RES_W-1:0] o_sample,
    output logic o_sample_strobe,
    output logic [`AOW_OFS_W-1:0] o_offset,
    output logic o_busy_n,
    output logic [`AOW_DATA_W-1:0] o_data,
    output logic o_data_oe
);
    // counter is eight bits and the walk needs at least two states
    if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : g_conv_range
        $error("CONV_CYCLES out of range");
    end

    // synchronised pins; cs/rd/wr idle high
    logic [5:0] pins_s;
    aow_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_sample_start_n, i_cs_n, i_rd_n, i_wr_n, i_mode}),
        .o_sync(pins_s)
    );
    logic start_s, cs_s, rd_s, wr_s;
    logic [1:0] mode_s;
    assign {start_s, cs_s, rd_s, wr_s, mode_s} = pins_s;

    // all state in one word; bus data and code ride two stages like the strobes
    typedef struct packed {
        aow_pkg::aow_state_t st;
        logic start_prev;
        logic wr_prev;
        logic [7:0] cnt;
        logic [`AOW_DATA_W-1:0] wdat_m;
        logic [`AOW_DATA_W-1:0] wdat_s;
        logic [`AOW_RES_W-1:0] code_m;
        logic [`AOW_RES_W-1:0] code_s;
        logic [`AOW_OFS_W-1:0] offset;
        logic [`AOW_RES_W-1:0] held;
        logic [`AOW_RES_W-1:0] result;
        logic [`AOW_RES_W-1:0] outreg;
        logic strobe;
        logic busy_n;
        logic [`AOW_DATA_W-1:0] dout;
        logic oe;
    } aow_core_state_t;

    aow_core_state_t s_q, s_d;
    logic start_fall, wr_rise;

    // next-state logic
    always_comb begin
        s_d = s_q;
        start_fall = s_q.start_prev && !start_s;
        wr_rise = !s_q.wr_prev && wr_s;
        s_d.start_prev = start_s;
        s_d.wr_prev = wr_s;
        s_d.strobe = 1'b0;
        // second stage reads only the first
        s_d.wdat_m = i_data;
        s_d.wdat_s = s_q.wdat_m;
        s_d.code_m = i_adc_code;
        s_d.code_s = s_q.code_m;
        // refused writes give no sign, so the host must watch busy_n first
        // write between conversions
        if (wr_rise && !cs_s && s_q.st == aow_pkg::AOW_IDLE) begin
            s_d.offset = s_q.wdat_s[`AOW_OFS_W-1:0];
        end
        case (s_q.st)
            aow_pkg::AOW_IDLE: begin
                if (start_fall) begin
                    s_d.st = aow_pkg::AOW_CONV;
                    s_d.held = s_q.code_s;
                    s_d.busy_n = 1'b0;
                    s_d.cnt = 8'(CONV_CYCLES - 1);
                    // delayed mode publishes previous result here
                    if (mode_s == `AOW_MODE_DLY) begin
                        s_d.outreg = s_q.result;
                        s_d.strobe = 1'b1;
                    end
                end
            end
            aow_pkg::AOW_CONV: begin
                if (s_q.cnt == 8'h01) begin
                    s_d.st = aow_pkg::AOW_DONE;
                end
                s_d.cnt = s_q.cnt - 8'h01;
            end
            aow_pkg::AOW_DONE: begin
                s_d.st = aow_pkg::AOW_IDLE;
                s_d.busy_n = 1'b1;
                // offset sign-extended and added to every result; the sum wraps, no clamp
                s_d.result = s_q.held + {{(`AOW_RES_W-`AOW_OFS_W){s_q.offset[`AOW_OFS_W-1]}},
                    s_q.offset};
                // immediate mode updates with busy rise
                if (mode_s == `AOW_MODE_IMM) begin
                    s_d.outreg = s_d.result;
                    s_d.strobe = 1'b1;
                end
            end
            default: begin
                s_d.st = aow_pkg::AOW_IDLE;
                s_d.busy_n = 1'b1;
            end
        endcase
        // drive only with cs and rd low
        s_d.oe = !cs_s && !rd_s && wr_s;
        s_d.dout = {1'b0, s_d.outreg};
    end

    // reset leaves busy_n high and the pins seen idle, so no false edge
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '{st: aow_pkg::AOW_IDLE, start_prev: 1'b1, wr_prev: 1'b1,
                     busy_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy_n = s_q.busy_n;
    assign o_data = s_q.dout;
    assign o_data_oe = s_q.oe;
    assign o_offset = s_q.offset;
    assign o_sample = s_q.outreg;
    assign o_sample_strobe = s_q.strobe;

    // checks below watch only what this block drives
    // busy stays low for two cycles after it falls
    AST_BUSY_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $fell(o_busy_n) |-> !o_busy_n [*2])
        else $error("busy rose too early");
    AST_START_BUSY: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (s_q.st == aow_pkg::AOW_IDLE && start_fall) |=> !o_busy_n)
        else $error("busy did not fall after start");
    // busy returns high in bounded time
    AST_BUSY_END: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $fell(o_busy_n) |-> ##[1:300] o_busy_n)
        else $error("conversion never ended");
    // bus drive only with cs and rd low
    AST_OE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_data_oe |-> ($past(cs_s) == 1'b0 && $past(rd_s) == 1'b0))
        else $error("data driven without read");
    // immediate mode updates at busy rise
    AST_IMM: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ($rose(o_busy_n) && $past(mode_s) == `AOW_MODE_IMM) |-> o_sample_strobe)
        else $error("no update at busy rise");
    AST_DLY: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ($fell(o_busy_n) && $past(mode_s) == `AOW_MODE_DLY) |-> o_sample_strobe)
        else $error("no update at start edge");
    AST_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_rise && !cs_s && s_q.st == aow_pkg::AOW_IDLE)
        |=> o_offset == $past(s_q.wdat_s[`AOW_OFS_W-1:0]))
        else $error("offset not stored");
    AST_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !wr_rise |=> $stable(o_offset))
        else $error("offset changed without write");
    // busy held low in every conversion cycle
    AST_BUSY_CONV: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (s_q.st == aow_pkg::AOW_CONV) |-> !o_busy_n)
        else $error("busy high during conversion");
    // busy high whenever no conversion runs
    AST_BUSY_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (s_q.st == aow_pkg::AOW_IDLE) |-> o_busy_n)
        else $error("busy low while idle");
    // countdown never runs out mid conversion
    AST_CNT: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (s_q.st == aow_pkg::AOW_CONV) |-> (s_q.cnt != 8'h00))
        else $error("conversion counter ran out");
    // offset frozen while a conversion runs
    AST_NO_WRITE_BUSY: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (s_q.st != aow_pkg::AOW_IDLE) |=> $stable(o_offset))
        else $error("offset changed during conversion");
    // output register moves only with its strobe
    AST_SAMPLE_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $changed(o_sample) |-> o_sample_strobe)
        else $error("sample changed without strobe");
    AST_STROBE_ONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_sample_strobe |=> !o_sample_strobe)
        else $error("strobe longer than one cycle");
    // overrange line unused, so the top bit stays low
    AST_DATA_TOP: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_data_oe |-> !o_data[`AOW_DATA_W-1])
        else $error("top data bit driven high");
endmodule

// ### src/aow_pkg.sv
// types shared by the converter control block
package aow_pkg;
    typedef enum logic [2:0] {
        AOW_IDLE = 3'h1,
        AOW_CONV = 3'h2,
        AOW_DONE = 3'h4
    } aow_state_t;
endpackage

// ### src/aow_sync.sv
// two-flop synchroniser for asynchronous pins
module aow_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] outv;
    } aow_sync_state_t;

    aow_sync_state_t s_q, s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d.meta = i_async;
        s_d.outv = s_q.meta;
    end

    // reset to the idle level so no false edge follows release
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= {INIT, INIT};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.outv;
endmodule

// ### test/aow_core_test.sv
// testbench for the converter offset and handshake block
`include "aow_consts.svh"
module aow_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, start_n, cs_n, rd_n, wr_n, busy_n, strobe, oe;
    logic [1:0] mode;
    logic [14:0] din, dout;
    logic [13:0] code, sample, exp_q, exp_s;
    logic [11:0] ofs, offset;
    int err_total, checks;
    int n0, lows, strobes;
    logic [13:0] cval;
    bit ok;
    localparam int CONV = 2;
    logic [11:0] ofs_tab [4] = '{12'haee, 12'h51e, 12'he00, 12'h100};
    aow_core #(.CONV_CYCLES(CONV)) aow_core_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_sample_start_n(start_n),
        .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_mode(mode),
        .i_data(din), .i_adc_code(code), .o_sample(sample),
        .o_sample_strobe(strobe), .o_offset(offset), .o_busy_n(busy_n),
        .o_data(dout), .o_data_oe(oe));
    aow_host aow_host_inst (
        .i_core_clk(clk), .i_busy_n(busy_n), .o_start_n(start_n),
        .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(din),
        .o_code(code));
    function automatic logic [13:0] conv(input logic [13:0] c, input logic [11:0] o);
        return c + {{2{o[11]}}, o}; // sign-extended, wraps at 14 bits
    endfunction
    task automatic cmp(input logic [14:0] got, input logic [14:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // strobe stands one cycle, so the falling edge sees each pulse once
    always @(negedge clk) begin
        if (strobe === 1'b1) begin
            strobes++;
        end
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        err_total = 0;
        checks = 0;
        rst_b = 1'b0;
        mode = `AOW_MODE_IMM;
        void'($urandom(32'h605151aa));
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        cmp(15'(busy_n), 15'h1, "busy at reset");
        aow_host_inst.idle(4);
        for (int i = 0; i < 12; i++) begin
            mode = (i < 6) ? `AOW_MODE_IMM : `AOW_MODE_DLY;
            ofs = (i < 4) ? ofs_tab[i] : 12'($urandom_range(2620)) - 12'd1310;
            cval = 14'($urandom);
            n0 = strobes;
            aow_host_inst.write_ofs(ofs);
            cmp(15'(offset), 15'(ofs), "offset");
            aow_host_inst.start(cval, ok, lows);
            cmp(15'(ok), 15'h1, "busy pulse");
            cmp(15'(lows), 15'(CONV), "busy length");
            exp_s = (i < 6) ? conv(cval, ofs) : exp_q; // delayed shows prior
            exp_q = conv(cval, ofs);
            cmp(15'(sample), 15'(exp_s), "sample");
            aow_host_inst.bus_rd(1'b1);
            cmp(15'(oe), 15'h1, "oe on");
            cmp(dout, {1'b0, exp_s}, "read data");
            cmp(15'(strobes - n0), 15'h1, "one update");
            aow_host_inst.bus_rd(1'b0);
            cmp(15'(oe), 15'h0, "oe off");
        end
        // second reset clears the offset
        rst_b = 1'b0;
        @(negedge clk);
        cmp(15'(offset), 15'h0, "offset reset");
        rst_b = 1'b1;
        aow_host_inst.idle(4);
        cval = 14'($urandom);
        aow_host_inst.start(cval, ok, lows);
        cmp(15'(ok), 15'h1, "busy after reset");
        cmp(15'(sample), 15'h0, "cleared result");
        aow_host_inst.start(14'($urandom), ok, lows);
        cmp(15'(sample), 15'(cval), "zero offset");
        print_verdict();
    end
endmodule

// ### test/aow_host.sv
// host model: offset writes, conversion starts and result reads
`include "aow_consts.svh"
module aow_host (
    input wire logic i_core_clk,
    input wire logic i_busy_n,
    output logic o_start_n,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [`AOW_DATA_W-1:0] o_data,
    output logic [`AOW_RES_W-1:0] o_code
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins idle high from time zero
    initial begin
        {o_start_n, o_cs_n, o_rd_n, o_wr_n} = 4'hf;
        o_data = 15'h0;
        o_code = 14'h0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic write_ofs(input logic [11:0] ofs);
        o_cs_n = 1'b0;
        o_data = {3'h0, ofs};
        idle(1);
        o_wr_n = 1'b0;
        idle(2);
        o_wr_n = 1'b1;
        idle(4);
        o_cs_n = 1'b1;
        o_data = ~o_data; // released bus flips to its inverse, so stale data would show
        idle(4);
    endtask
    // four-cycle quiet gap, then start without checking busy_n
    // input moves once busy fell, so a late sample shows
    task automatic start(input logic [13:0] code, output bit ok, output int lows);
        int n;
        bit fell;
        o_code = code;
        idle(4);
        o_start_n = 1'b0;
        n = 0;
        lows = 0;
        while (i_busy_n !== 1'b0 && n < 8) begin
            idle(1);
            n++;
        end
        fell = (i_busy_n === 1'b0);
        o_code = ~code;
        o_start_n = 1'b1;
        while (i_busy_n !== 1'b1 && n < 30) begin
            idle(1);
            n++;
            lows++;
        end
        ok = fell && (n < 30);
    endtask
    // read strobes after end of conversion
    task automatic bus_rd(input logic en);
        o_cs_n = ~en;
        o_rd_n = ~en;
        idle(4);
    endtask
endmodule
